// file: shared/fbc_params.svh
// timing constants and bus widths for the flash bus host controller
`ifndef FBC_PARAMS_SVH
`define FBC_PARAMS_SVH
`define FBC_CLK_PERIOD_NS 50
`define FBC_SELECT_ACCESS_NS 90
`define FBC_SELECT_ACCESS_CYC ((`FBC_SELECT_ACCESS_NS + `FBC_CLK_PERIOD_NS - 1) / `FBC_CLK_PERIOD_NS)
`define FBC_WRITE_PULSE_NS 50
`define FBC_WRITE_PULSE_CYC ((`FBC_WRITE_PULSE_NS + `FBC_CLK_PERIOD_NS - 1) / `FBC_CLK_PERIOD_NS)
`define FBC_CLEAR_PULSE_MIN_NS 500
`define FBC_CLEAR_PULSE_MIN_CYC ((`FBC_CLEAR_PULSE_MIN_NS + `FBC_CLK_PERIOD_NS - 1) / `FBC_CLK_PERIOD_NS)
`define FBC_CLEAR_RECOVER_NS 50
`define FBC_CLEAR_RECOVER_CYC ((`FBC_CLEAR_RECOVER_NS + `FBC_CLK_PERIOD_NS - 1) / `FBC_CLK_PERIOD_NS)
`define FBC_ADDR_W 18
`define FBC_DATA_W 8
`endif

// file: shared/fbc_pkg.sv
// types for the flash bus host controller
package fbc_pkg;
  typedef enum logic [1:0]
  {
    FBC_OP_READ = 2'h0,
    FBC_OP_WRITE = 2'h1,
    FBC_OP_CLEAR = 2'h2
  } fbc_op_t;

  typedef struct packed
  {
    fbc_op_t op;
    logic [17:0] addr;
    logic [7:0] wdata;
  } fbc_req_t;

  typedef struct packed
  {
    logic sel_n;
    logic gate_n;
    logic wstb_n;
    logic clr_n;
  } fbc_ctl_t;

  typedef enum logic [5:0]
  {
    FBC_ST_IDLE = 6'h01,
    FBC_ST_READ = 6'h02,
    FBC_ST_WRITE = 6'h04,
    FBC_ST_WREC = 6'h08,
    FBC_ST_CLEAR = 6'h10,
    FBC_ST_CREC = 6'h20
  } fbc_state_t;
endpackage

// file: hdl/fbc_host.sv
// host controller driving the parallel flash bus pins
`timescale 1ns/1ns
`include "fbc_params.svh"

module fbc_host
#(
  parameter int ACCESS_CYC = `FBC_SELECT_ACCESS_CYC,
  parameter bit HAS_CLEAR = 1'b1
)
(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic REQ_VALID,
  input wire fbc_pkg::fbc_req_t REQ,
  output logic REQ_READY,
  output logic RSP_VALID,
  output logic [`FBC_DATA_W-1:0] RSP_DATA,
  output logic ABORTED,
  output fbc_pkg::fbc_ctl_t CTL,
  output logic [`FBC_ADDR_W-1:0] ADDR_BUS,
  output logic [`FBC_DATA_W-1:0] DATA_BUS_O,
  output logic DATA_BUS_OE_N,
  input wire logic [`FBC_DATA_W-1:0] DATA_BUS_I
);
  localparam int CNT_W = 8;

  fbc_pkg::fbc_state_t state_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [`FBC_DATA_W-1:0] din_meta_reg;
  logic [`FBC_DATA_W-1:0] din_sync_reg;
  logic busy_reg;
  logic write_take;
  logic clear_done;

  // =====================================================
  // data input synchroniser
  // =====================================================
  // the device answers without a clock, so two stages before any use
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      din_meta_reg <= 8'h00;
      din_sync_reg <= 8'h00;
    end
    else
    begin
      din_meta_reg <= DATA_BUS_I;
      din_sync_reg <= din_meta_reg;
    end
  end

  // =====================================================
  // abort tracking
  // =====================================================
  // a write may leave the device programming or erasing; a deselect lets it
  // run on, only a clear cuts it short, so that is when the requester hears of it
  assign write_take = (state_reg == fbc_pkg::FBC_ST_IDLE) && REQ_VALID && REQ_READY
    && (REQ.op == fbc_pkg::FBC_OP_WRITE);
  assign clear_done = (state_reg == fbc_pkg::FBC_ST_CREC)
    && (cnt_reg >= CNT_W'(`FBC_CLEAR_RECOVER_CYC - 1));

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      busy_reg <= 1'b0;
      ABORTED <= 1'b0;
    end
    else
    begin
      ABORTED <= clear_done && busy_reg;
      // a new write outranks the end of a clear, though serial requests keep them apart
      if (write_take)
        busy_reg <= 1'b1;
      else if (clear_done)
        busy_reg <= 1'b0;
    end
  end

  // =====================================================
  // sequencer
  // =====================================================
  // one request at a time; every pin changes on the clock edge only
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      state_reg <= fbc_pkg::FBC_ST_IDLE;
      cnt_reg <= 8'h00;
      RSP_VALID <= 1'b0;
      RSP_DATA <= 8'h00;
      REQ_READY <= 1'b0;
      CTL <= 4'hF;
      ADDR_BUS <= 18'h00000;
      DATA_BUS_O <= 8'h00;
      DATA_BUS_OE_N <= 1'b1;
    end
    else
    begin
      RSP_VALID <= 1'b0;
      case (state_reg)
        fbc_pkg::FBC_ST_IDLE:
        begin
          REQ_READY <= 1'b1;
          CTL <= 4'hF; // idle is standby
          DATA_BUS_OE_N <= 1'b1;
          if (REQ_VALID && REQ_READY)
          begin
            REQ_READY <= 1'b0;
            ADDR_BUS <= REQ.addr;
            DATA_BUS_O <= REQ.wdata;
            cnt_reg <= 8'h00;
            if (REQ.op == fbc_pkg::FBC_OP_WRITE)
            begin
              // command and erase sequences go out as writes
              CTL <= {1'b0, 1'b1, 1'b0, 1'b1};
              DATA_BUS_OE_N <= 1'b0;
              state_reg <= fbc_pkg::FBC_ST_WRITE;
            end
            else if (REQ.op == fbc_pkg::FBC_OP_CLEAR && HAS_CLEAR)
            begin
              CTL <= {1'b1, 1'b1, 1'b1, 1'b0};
              state_reg <= fbc_pkg::FBC_ST_CLEAR;
            end
            else if (REQ.op == fbc_pkg::FBC_OP_CLEAR)
            begin
              // no clear pin on this variant: answer at once
              RSP_VALID <= 1'b1;
              RSP_DATA <= 8'h00;
              state_reg <= fbc_pkg::FBC_ST_IDLE;
            end
            else
            begin
              // array, identification and status all read alike
              CTL <= {1'b0, 1'b0, 1'b1, 1'b1};
              state_reg <= fbc_pkg::FBC_ST_READ;
            end
          end
        end
        fbc_pkg::FBC_ST_READ:
        begin
          // two extra cycles cover the input synchroniser
          if (cnt_reg >= CNT_W'(ACCESS_CYC + 2))
          begin
            RSP_VALID <= 1'b1;
            RSP_DATA <= din_sync_reg;
            CTL <= 4'hF;
            state_reg <= fbc_pkg::FBC_ST_IDLE;
          end
          else
            cnt_reg <= cnt_reg + 8'h01;
        end
        fbc_pkg::FBC_ST_WRITE:
        begin
          if (cnt_reg >= CNT_W'(`FBC_WRITE_PULSE_CYC - 1))
          begin
            CTL <= 4'hF; // strobe rises while data still driven
            cnt_reg <= 8'h00;
            state_reg <= fbc_pkg::FBC_ST_WREC;
          end
          else
            cnt_reg <= cnt_reg + 8'h01;
        end
        fbc_pkg::FBC_ST_WREC:
        begin
          DATA_BUS_OE_N <= 1'b1;
          RSP_VALID <= 1'b1;
          RSP_DATA <= 8'h00;
          state_reg <= fbc_pkg::FBC_ST_IDLE;
        end
        fbc_pkg::FBC_ST_CLEAR:
        begin
          if (cnt_reg >= CNT_W'(`FBC_CLEAR_PULSE_MIN_CYC - 1))
          begin
            CTL <= 4'hF; // device back in array read
            cnt_reg <= 8'h00;
            state_reg <= fbc_pkg::FBC_ST_CREC;
          end
          else
            cnt_reg <= cnt_reg + 8'h01;
        end
        fbc_pkg::FBC_ST_CREC:
        begin
          if (cnt_reg >= CNT_W'(`FBC_CLEAR_RECOVER_CYC - 1))
          begin
            // abort flag rises with this response when a write went out since the last clear
            RSP_VALID <= 1'b1;
            RSP_DATA <= 8'h00;
            state_reg <= fbc_pkg::FBC_ST_IDLE;
          end
          else
            cnt_reg <= cnt_reg + 8'h01;
        end
        default:
        begin
          state_reg <= fbc_pkg::FBC_ST_IDLE;
          CTL <= 4'hF;
          DATA_BUS_OE_N <= 1'b1;
        end
      endcase
    end
  end
endmodule

// file: verif/fbc_host_props.sv
// pin timing checker for the flash host
`timescale 1ns/1ns
module fbc_host_props
(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic REQ_VALID,
  input wire logic REQ_READY,
  input wire logic RSP_VALID,
  input wire logic ABORTED,
  input wire fbc_pkg::fbc_ctl_t CTL,
  input wire logic DATA_BUS_OE_N
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  a_read_pins: assert property (!CTL.gate_n |-> !CTL.sel_n && CTL.wstb_n && DATA_BUS_OE_N)
    else $error("gate low outside a plain read");
  a_write_pins: assert property (!CTL.wstb_n |-> !CTL.sel_n && CTL.gate_n && !DATA_BUS_OE_N)
    else $error("strobe low outside a plain write");
  a_read_span: assert property ($fell(CTL.gate_n) |-> !CTL.gate_n[*5] ##1 (CTL.gate_n && RSP_VALID))
    else $error("read cycle length wrong");
  a_write_span: assert property ($fell(CTL.wstb_n) |=> CTL.wstb_n ##1 RSP_VALID)
    else $error("write pulse length wrong");
  a_clear_width: assert property ($fell(CTL.clr_n) |-> !CTL.clr_n[*8] ##1 !CTL.clr_n[*2] ##1 CTL.clr_n)
    else $error("clear pulse width wrong");
  a_clear_quiet: assert property (!CTL.clr_n |-> CTL.sel_n && CTL.gate_n && CTL.wstb_n)
    else $error("bus active during clear");
  a_idle_standby: assert property (REQ_READY |-> CTL == 4'hF)
    else $error("pins not in standby while idle");
  a_abort_rsp: assert property (ABORTED |-> RSP_VALID ##1 REQ_READY)
    else $error("abort flag without response");
endmodule
bind fbc_host fbc_host_props u_props(.REF_CLK(REF_CLK), .RST(RST), .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY),
  .RSP_VALID(RSP_VALID), .ABORTED(ABORTED), .CTL(CTL), .DATA_BUS_OE_N(DATA_BUS_OE_N));

// file: verif/fbc_flash_model.sv
// behavioural flash device on the far side
`timescale 1ns/1ns
module fbc_flash_model
(
  input wire fbc_pkg::fbc_ctl_t CTL,
  input wire logic [17:0] ADDR_BUS,
  input wire logic [7:0] DATA_BUS_O,
  input wire logic DATA_BUS_OE_N,
  output logic [7:0] DATA_BUS_I
);
  parameter logic [7:0] ID_CODE = 8'hA5; // arbitrary value
  logic id_mode = 1'b0;
  wire rd = CTL.clr_n && !CTL.sel_n && !CTL.gate_n;
  wire [7:0] val = id_mode ? ID_CODE : ADDR_BUS[7:0] ^ 8'h3C;
  // floated bus shows the inverse so a stale sample cannot match
  assign #90 DATA_BUS_I = !DATA_BUS_OE_N ? DATA_BUS_O : rd ? val : ~val;
  // one process owns the mode: a write sets or drops it, a clear edge drops it
  always @(negedge CTL.wstb_n or negedge CTL.clr_n)
    #1 id_mode = CTL.clr_n && !CTL.wstb_n && (DATA_BUS_O == 8'h90);
endmodule

// file: verif/fbc_host_bench.sv
// self-checking bench for the flash host
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module fbc_host_bench;
  logic REF_CLK = 0, RST = 1, REQ_VALID = 0, REQ_READY, RSP_VALID, ABORTED, DATA_BUS_OE_N;
  fbc_pkg::fbc_req_t REQ = '0;
  fbc_pkg::fbc_ctl_t CTL;
  logic [7:0] RSP_DATA, DATA_BUS_O, DATA_BUS_I;
  logic [17:0] ADDR_BUS;
  int mismatches = 0, n_compared = 0, cycles = 0;
  fbc_host DUT(.REF_CLK(REF_CLK), .RST(RST), .REQ_VALID(REQ_VALID), .REQ(REQ), .REQ_READY(REQ_READY),
    .RSP_VALID(RSP_VALID), .RSP_DATA(RSP_DATA), .ABORTED(ABORTED), .CTL(CTL), .ADDR_BUS(ADDR_BUS),
    .DATA_BUS_O(DATA_BUS_O), .DATA_BUS_OE_N(DATA_BUS_OE_N), .DATA_BUS_I(DATA_BUS_I));
  fbc_flash_model u_flash(.CTL(CTL), .ADDR_BUS(ADDR_BUS), .DATA_BUS_O(DATA_BUS_O),
    .DATA_BUS_OE_N(DATA_BUS_OE_N), .DATA_BUS_I(DATA_BUS_I));
  // second controller built for the variant without a clear pin
  logic nc_valid = 0, nc_ready, nc_rsp, nc_abort;
  fbc_pkg::fbc_ctl_t nc_ctl;
  fbc_host #(.HAS_CLEAR(1'b0)) DUT_NC(.REF_CLK(REF_CLK), .RST(RST), .REQ_VALID(nc_valid), .REQ(REQ),
    .REQ_READY(nc_ready), .RSP_VALID(nc_rsp), .RSP_DATA(), .ABORTED(nc_abort), .CTL(nc_ctl), .ADDR_BUS(),
    .DATA_BUS_O(), .DATA_BUS_OE_N(), .DATA_BUS_I(8'h00));
  always #25 REF_CLK = ~REF_CLK;
  always @(posedge REF_CLK)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      mismatches++;
      report_and_stop();
    end
  end
  // ==========
  // scenarios
  task automatic run(input fbc_pkg::fbc_op_t op, input logic [17:0] a, input logic [7:0] d);
    @(negedge REF_CLK);
    REQ = {op, a, d};
    REQ_VALID = 1;
    while (!REQ_READY) @(negedge REF_CLK);
    @(negedge REF_CLK);
    REQ_VALID = 0;
    while (!RSP_VALID) @(negedge REF_CLK);
  endtask
  task automatic t_array_read();
    run(fbc_pkg::FBC_OP_READ, 18'h3FF12, 8'h00);
    `CHK("array", 8'h2E, RSP_DATA)
  endtask
  task automatic t_erase();
    // stand-in erase byte aimed at one sector through its upper address bits
    run(fbc_pkg::FBC_OP_WRITE, 18'h3A000, 8'h30);
    `CHK("sector", 5'h1D, ADDR_BUS[17:13])
    `CHK("wr_float", 1'b1, DATA_BUS_OE_N)
  endtask
  task automatic t_id_read();
    run(fbc_pkg::FBC_OP_WRITE, 18'h00555, 8'h90);
    `CHK("wdata", 8'h00, RSP_DATA)
    run(fbc_pkg::FBC_OP_READ, 18'h00001, 8'h00);
    `CHK("ident", 8'hA5, RSP_DATA)
  endtask
  task automatic t_clear();
    run(fbc_pkg::FBC_OP_CLEAR, 18'h00000, 8'h00);
    `CHK("abort", 1'b1, ABORTED)
    run(fbc_pkg::FBC_OP_READ, 18'h00021, 8'h00);
    `CHK("reread", 8'h1D, RSP_DATA)
    run(fbc_pkg::FBC_OP_CLEAR, 18'h00000, 8'h00);
    `CHK("no_abort", 1'b0, ABORTED)
  endtask
  task automatic t_no_clear();
    @(negedge REF_CLK);
    REQ = {fbc_pkg::FBC_OP_CLEAR, 18'h00000, 8'h00};
    nc_valid = 1;
    while (!nc_ready) @(negedge REF_CLK);
    @(negedge REF_CLK);
    nc_valid = 0;
    `CHK("nc_rsp", 1'b1, nc_rsp)
    `CHK("nc_pins", 4'hF, nc_ctl)
    `CHK("nc_abort", 1'b0, nc_abort)
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge REF_CLK);
    @(negedge REF_CLK) RST = 0;
    t_array_read();
    t_erase();
    t_id_read();
    t_clear();
    t_no_clear();
    report_and_stop();
  end
endmodule
